// file: tpo_pkg.sv
// Purpose: Constants shared by the timing pattern output unit
// Assumes: Four 4-bit groups, four timer channels
// Notes:   Reset values follow the control register defaults
`default_nettype none
package tpo_pkg;
  localparam int unsigned TPO_GROUPS = 4;
  localparam int unsigned TPO_GROUP_W = 4;
  localparam int unsigned TPO_CHANNELS = 4;
  localparam int unsigned TPO_BITS = 16;
  localparam logic [15:0] TPO_DATA_RST = 16'h0000;
  localparam logic [15:0] TPO_ENABLE_RST = 16'h0000;
  localparam logic [15:0] TPO_DIR_RST = 16'h0000;
  // All groups on channel 3 after reset
  localparam logic [7:0] TPO_TRIG_SEL_RST = 8'hff;
  localparam logic [3:0] TPO_NOV_RST = 4'h0;
endpackage
`default_nettype wire

// file: tpo_timer_model.sv
// Purpose: Timer channels giving compare and capture pulses
// Assumes: Shared period; counter clears at register B match
// Notes:   Pulses change on falling edge, away from sampling
`default_nettype none
module tpo_timer_model #(parameter int MARGIN_CNT = 3, parameter int PERIOD_CNT = 6) (
  input  wire logic       core_clk,
  input  wire logic [3:0] run,
  input  wire logic [3:0] capm,
  output logic      [3:0] cmp_a = 4'h0,
  output logic      [3:0] cmp_b = 4'h0,
  output logic      [3:0] cap_a = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q = 0;
  always @(negedge core_clk) begin
    cnt_q <= (cnt_q == PERIOD_CNT) ? 0 : cnt_q + 1;
    cmp_a <= (cnt_q == MARGIN_CNT) ? run & ~capm : 4'h0;
    cap_a <= (cnt_q == MARGIN_CNT) ? run & capm : 4'h0;
    cmp_b <= (cnt_q == PERIOD_CNT) ? run : 4'h0;
  end
endmodule // tpo_timer_model
`default_nettype wire

// file: tpo_unit.sv
// Purpose: Timing pattern output unit, 16 outputs in four 4-bit groups
// Assumes: Timer trigger inputs are single-cycle pulses on core_clk
// Notes:   Copy happens on the rising edge that samples the trigger pulse
// Notes on behaviour
// - Drive pattern only when direction set and timer output enable clear
// - Enabled output shows current port data first
// - Trigger copies enabled next-data into port data
// - Pin function chosen by enable and direction
// - Enable without direction: input, data still updated
// - Capture on register A replaces compare match
// - Timer output owns pin, pattern not driven
// - Copy happens regardless of pin owner
// - Non-overlap: all bits copied at compare A
// - Non-overlap: only zero bits copied at compare B
// - Two-bit select picks channel per group
// - Normal mode updates only at compare A
`default_nettype none
module tpo_unit
  import tpo_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] next_data,
  input  wire logic [15:0] next_data_enable,
  input  wire logic [15:0] port_direction,
  input  wire logic        port_data_we,
  input  wire logic [15:0] port_data_wdata,
  input  wire logic [7:0]  trigger_select,
  input  wire logic [3:0]  group_nonoverlap_enable,
  input  wire logic [3:0]  timer_compare_a,
  input  wire logic [3:0]  timer_compare_b,
  input  wire logic [3:0]  timer_capture_a,
  input  wire logic [3:0]  timer_capture_mode,
  input  wire logic [15:0] timer_output_enable,
  output logic      [15:0] port_data,
  output logic      [15:0] pattern_out,
  output logic      [15:0] pattern_oe
);
  import tpo_pkg::*;

  logic [15:0] port_data_q;
  logic [15:0] pattern_out_q;
  logic [15:0] pattern_oe_q;
  logic [3:0]  event_a;
  logic [3:0]  event_b;
  logic [15:0] copy_mask;

  // Register A event: capture when configured as capture register
  function automatic logic chan_event_a(input logic [3:0] cmp, input logic [3:0] cap,
                                        input logic [3:0] capm, input logic [1:0] ch);
    chan_event_a = capm[ch] ? cap[ch] : cmp[ch];
  endfunction

  // Trigger decode is purely combinational so the copy lands on the very next edge
  always_comb begin
    copy_mask = '0;
    event_a   = '0;
    event_b   = '0;
    for (int g = 0; g < TPO_GROUPS; g++) begin
      event_a[g] = chan_event_a(timer_compare_a, timer_capture_a, timer_capture_mode,
                                trigger_select[2*g +: 2]);
      event_b[g] = group_nonoverlap_enable[g] & timer_compare_b[trigger_select[2*g +: 2]];
      for (int b = 0; b < TPO_GROUP_W; b++) begin
        // Normal mode reacts to A only; B moves only zeros
        if (event_a[g]) begin
          copy_mask[g*TPO_GROUP_W + b] = next_data_enable[g*TPO_GROUP_W + b];
        end else if (event_b[g]) begin
          copy_mask[g*TPO_GROUP_W + b] = next_data_enable[g*TPO_GROUP_W + b]
                                         & ~next_data[g*TPO_GROUP_W + b];
        end
      end
    end
  end

  // Trigger copy wins over a software write; pattern bits are read-only
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_data_q <= TPO_DATA_RST;
    end else begin
      for (int i = 0; i < TPO_BITS; i++) begin
        if (copy_mask[i]) begin
          port_data_q[i] <= next_data[i];
        end else if (port_data_we && !next_data_enable[i]) begin
          port_data_q[i] <= port_data_wdata[i];
        end
      end
    end
  end

  // Output stage registered; reflects stored data so first value is current
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pattern_out_q <= TPO_DATA_RST;
      pattern_oe_q  <= TPO_DIR_RST;
    end else begin
      pattern_out_q <= port_data_q;
      pattern_oe_q  <= port_direction & ~timer_output_enable;
    end
  end

  assign port_data   = port_data_q;
  assign pattern_out = pattern_out_q;
  assign pattern_oe  = pattern_oe_q;

  // Channel code of group 0, used by the capture checks
  logic [1:0] sel0;
  logic [1:0] sel2;
  assign sel0 = trigger_select[1:0];
  assign sel2 = trigger_select[5:4];

  // Copy path checks

  chk_copy_on_a: assert property (@(posedge core_clk) disable iff (!resetn)
    event_a[0] && next_data_enable[0] |=> port_data_q[0] == $past(next_data[0]))
    else $error("group 0 bit 0 not copied at A");

  chk_b_zero_only: assert property (@(posedge core_clk) disable iff (!resetn)
    !event_a[0] && event_b[0] && next_data[1] && next_data_enable[1] |=> $stable(port_data_q[1]))
    else $error("one bit copied at B");

  chk_b_zero_copy: assert property (@(posedge core_clk) disable iff (!resetn)
    !event_a[0] && event_b[0] && !next_data[2] && next_data_enable[2] |=> !port_data_q[2])
    else $error("zero bit not copied at B");

  chk_normal_ignores_b: assert property (@(posedge core_clk) disable iff (!resetn)
    !group_nonoverlap_enable[0] && !event_a[0] && !port_data_we |=> $stable(port_data_q[3:0]))
    else $error("normal mode changed without A");

  chk_disabled_bit: assert property (@(posedge core_clk) disable iff (!resetn)
    !next_data_enable[4] && !port_data_we |=> $stable(port_data_q[4]))
    else $error("disabled bit changed");

  // Input pins still take the copy, even though nothing is driven
  chk_copy_no_dir: assert property (@(posedge core_clk) disable iff (!resetn)
    event_a[1] && next_data_enable[5] && !port_direction[5]
    |=> port_data_q[5] == $past(next_data[5]))
    else $error("input pin bit not copied");

  // Timer-owned pins keep their data current for a later hand-back
  chk_copy_timer_pin: assert property (@(posedge core_clk) disable iff (!resetn)
    event_a[0] && next_data_enable[1] && timer_output_enable[1]
    |=> port_data_q[1] == $past(next_data[1]))
    else $error("timer pin bit not copied");

  chk_capture_copy: assert property (@(posedge core_clk) disable iff (!resetn)
    timer_capture_mode[sel0] && timer_capture_a[sel0] && next_data_enable[3]
    |=> port_data_q[3] == $past(next_data[3]))
    else $error("capture did not copy");

  chk_sel_route: assert property (@(posedge core_clk) disable iff (!resetn)
    timer_compare_a[sel2] && !timer_capture_mode[sel2]
    |-> event_a[2])
    else $error("selected channel not routed");

  // Software write path

  chk_write_refused: assert property (@(posedge core_clk) disable iff (!resetn)
    port_data_we && next_data_enable[8] && !copy_mask[8]
    |=> $stable(port_data_q[8]))
    else $error("write reached read-only bit");

  chk_write_lands: assert property (@(posedge core_clk) disable iff (!resetn)
    port_data_we && !next_data_enable[9]
    |=> port_data_q[9] == $past(port_data_wdata[9]))
    else $error("generic write lost");

  // Pin stage checks, then the capture-mode select check

  chk_oe_timer: assert property (@(posedge core_clk) disable iff (!resetn)
    timer_output_enable[5] |=> !pattern_oe[5])
    else $error("pattern driven on timer pin");

  chk_oe_dir: assert property (@(posedge core_clk) disable iff (!resetn)
    port_direction[6] && !timer_output_enable[6] |=> pattern_oe[6])
    else $error("output not enabled");

  chk_oe_input: assert property (@(posedge core_clk) disable iff (!resetn)
    !port_direction[7]
    |=> !pattern_oe[7])
    else $error("input pin driven");

  // Pin always shows the stored word, so enabling output shows current data
  chk_out_pipe: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1
    |=> pattern_out == $past(port_data_q))
    else $error("pin does not follow port data");

  chk_out_follow: assert property (@(posedge core_clk) disable iff (!resetn)
    event_a[3] && next_data_enable[12] |=> ##1 pattern_out[12] == $past(next_data[12], 2))
    else $error("output late after trigger");

  chk_capture_sel: assert property (@(posedge core_clk) disable iff (!resetn)
    timer_capture_mode[sel0] && !timer_capture_a[sel0] |-> !event_a[0])
    else $error("compare used in capture mode");

  // Main scenarios

  cov_normal: cover property (@(posedge core_clk) event_a[0] && !group_nonoverlap_enable[0]);
  cov_nov_b: cover property (@(posedge core_clk) event_b[1] && !event_a[1]);
  cov_capture: cover property (@(posedge core_clk) timer_capture_mode[sel0] && event_a[0]);
  cov_write_refused: cover property (@(posedge core_clk) port_data_we && |next_data_enable);
  cov_timer_pin: cover property (@(posedge core_clk) event_a[0] && timer_output_enable[1]);

endmodule  // tpo_unit
`default_nettype wire

// file: tpo_unit_tb_top.sv
// Purpose: Self-checking bench for the timing pattern output unit
// Assumes: Inputs change on falling edge; software port write used only in t_write
// Notes:   One timer channel runs at a time
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("mismatch %0t %h", $time, a); end end
module tpo_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tpo_pkg::*;
  logic core_clk = 0, resetn = 0, we = 0;
  logic [15:0] wd = 0;
  logic [15:0] nd = 0, nde = 0, dir = 0, toe = 0, pd, po, poe;
  logic [7:0] sel = TPO_TRIG_SEL_RST;
  logic [3:0] nov = TPO_NOV_RST, run = 0, capm = 0, ca, cb, cc;
  int mismatches = 0, checks_done = 0;
  always #25 core_clk = ~core_clk;
  tpo_timer_model tmr (.core_clk(core_clk), .run(run), .capm(capm), .cmp_a(ca), .cmp_b(cb), .cap_a(cc));
  tpo_unit dut (.core_clk(core_clk), .resetn(resetn), .next_data(nd), .next_data_enable(nde),
    .port_direction(dir), .port_data_we(we), .port_data_wdata(wd), .trigger_select(sel),
    .group_nonoverlap_enable(nov), .timer_compare_a(ca), .timer_compare_b(cb), .timer_capture_a(cc),
    .timer_capture_mode(capm), .timer_output_enable(toe), .port_data(pd), .pattern_out(po), .pattern_oe(poe));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Returns on the falling edge after the rising edge that follows the copy edge
  task automatic wait_ev(input int k);
    int n;
    logic hit;
    n = 0;
    hit = 0;
    while (!hit && n < 20) begin
      @(posedge core_clk);
      n++;
      hit = (k == 0) ? |ca : (k == 1) ? |cb : |cc;
    end
    if (!hit) begin
      mismatches++;
      final_report();
    end
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic t_normal();
    for (int c = 0; c < 4; c++) begin
      sel = {4{c[1:0]}};
      run = 4'h1 << c;
      nd = 16'h5a3c ^ 16'(c);
      wait_ev(0);
      `CHK(pd, 16'h5a3c ^ 16'(c))
      nd = 16'h0000;
      wait_ev(1);
      `CHK(pd, 16'h5a3c ^ 16'(c))
      `CHK(po, 16'h5a3c ^ 16'(c))
    end
    $display("normal done");
  endtask
  task automatic t_mask();
    nde = 16'h00ff;
    dir = 16'h0f0f;
    toe = 16'h0003;
    nd = 16'hffff;
    wait_ev(0);
    `CHK(pd, 16'h5aff)
    `CHK(poe, 16'h0f0c)
    $display("mask done");
  endtask
  task automatic t_nov();
    run = 4'h1;
    sel = 8'h00;
    nov = 4'hf;
    nde = 16'hffff;
    nd = 16'h00ff;
    wait_ev(0);
    `CHK(pd, 16'h00ff)
    nd = 16'h0ff0;
    wait_ev(1);
    `CHK(pd, 16'h00f0)
    wait_ev(0);
    `CHK(pd, 16'h0ff0)
    $display("nonoverlap done");
  endtask
  task automatic t_cap();
    nov = 4'h0;
    capm = 4'h1;
    nd = 16'h1234;
    wait_ev(2);
    `CHK(pd, 16'h1234)
    $display("capture done");
  endtask
  // Write lands only on bits whose next-data enable is clear
  task automatic t_write();
    nde = 16'h00ff;
    wd = 16'hffff;
    we = 1;
    @(negedge core_clk);
    we = 0;
    `CHK(pd, 16'hff34)
    $display("write done");
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    `CHK(pd, TPO_DATA_RST)
    resetn = 1;
    nde = 16'hffff;
    dir = 16'hffff;
    repeat (3) @(negedge core_clk);
    `CHK(po, 16'h0000)
    `CHK(poe, 16'hffff)
    t_normal();
    t_mask();
    t_nov();
    t_cap();
    t_write();
    final_report();
  end
endmodule // tpo_unit_tb_top
`default_nettype wire
